// ---- src/grc_top.sv ----
// Gated replay sequencer with AXI4-Lite registers.
// Assumes one sample_tick pulse per sample period and a trigger input synchronous to aclk.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module grc_top
   import grc_pkg::*;
#(
   parameter int CNT_W = 32
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [GRC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [GRC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trig_in,
   input wire logic sample_tick,
   output logic sample_strobe,
   output logic replay_active,
   output logic replay_done
);
   typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_RUN, ST_DONE} grc_state_type;

   grc_state_type st;
   logic [31:0] ctrl_reg;
   logic [31:0] config_reg;
   logic [31:0] rate_reg;
   logic [31:0] total_reg;
   logic cfg_error;
   logic [GRC_ADDR_W-1:0] aw_addr;
   logic aw_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_full;
   logic wr_fire;
   logic ctrl_wr;
   logic en_wr;
   logic mode_ok;
   logic arm_req;
   logic fifo_mode;
   logic [1:0] chan_cfg;
   logic [3:0] align_len;
   logic [3:0] lead_len;
   logic [3:0] delay_cnt;
   logic [CNT_W-1:0] run_idx;
   logic [CNT_W-1:0] total_cnt;
   logic [3:0] idx_low;
   logic boundary;
   logic hit_total;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;

   grc_gate_if gif ();

   grc_gate_detect u_detect (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .trig_in(trig_in),
      .gif(gif)
   );

   function automatic logic [31:0] merge_strb(logic [31:0] old_v, logic [31:0] new_v,
                                              logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      end
      return res;
   endfunction : merge_strb

   assign fifo_mode = ctrl_reg[GRC_CTRL_FIFO_BIT];
   assign chan_cfg = config_reg[GRC_CFG_CHAN_LSB +: 2];
   assign gif.mode = config_reg[GRC_CFG_MODE_LSB +: 3];
   assign mode_ok = (gif.mode == GATE_RISING_EDGE_MODE) ||
                    (gif.mode == GATE_FALLING_EDGE_MODE);
   assign wr_fire = aw_full && w_full && !s_axi_bvalid;
   assign ctrl_wr = wr_fire && aw_addr == GRC_CTRL_OFS && w_strb[0];
   assign en_wr = w_data[GRC_CTRL_EN_BIT];
   assign arm_req = ctrl_wr && en_wr && mode_ok && (st == ST_IDLE || st == ST_DONE);

   // Alignment and lead-in come from the same channel/mode classes
   always_comb
   begin
      align_len = GRC_ALIGN_8;
      lead_len = (rate_reg < GRC_RATE_5M) ? GRC_LEAD_1CH_LO : GRC_LEAD_1CH_HI;
      if ((chan_cfg == GRC_CH_TWO_SPLIT && fifo_mode) || chan_cfg == GRC_CH_TWO_SAME ||
          (chan_cfg == GRC_CH_FOUR && !fifo_mode))
      begin
         align_len = GRC_ALIGN_4;
         lead_len = (rate_reg < GRC_RATE_2M5) ? GRC_LEAD_2CH_LO : GRC_LEAD_2CH_HI;
      end
      else if (chan_cfg == GRC_CH_FOUR)
      begin
         align_len = GRC_ALIGN_2;
         lead_len = (rate_reg < GRC_RATE_1M25) ? GRC_LEAD_4CH_LO : GRC_LEAD_4CH_HI;
      end
   end

   assign idx_low = run_idx[3:0] + 4'h1;
   assign boundary = (idx_low & (align_len - 4'h1)) == 4'h0;
   assign hit_total = !fifo_mode && (total_cnt + CNT_W'(1)) >= CNT_W'(total_reg);

   // AXI write address and data are captured independently, then applied together
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= GRC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awready && s_axi_awvalid)
         begin
            s_axi_awready <= 1'b0;
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid)
         begin
            s_axi_wready <= 1'b0;
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr <= GRC_COUNT_OFS && aw_addr[1:0] == 2'h0) ?
                           GRC_RESP_OKAY : GRC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= GRC_CTRL_RST;
         config_reg <= GRC_CONFIG_RST;
         rate_reg <= GRC_RATE_RST;
         total_reg <= GRC_TOTAL_RST;
         cfg_error <= 1'b0;
      end
      else if (ce && wr_fire)
      begin
         unique case (aw_addr)
            GRC_CTRL_OFS:
            begin
               ctrl_reg <= merge_strb(ctrl_reg, w_data, w_strb);
               if (w_strb[0] && en_wr && !mode_ok)
                  cfg_error <= 1'b1;
            end
            GRC_CONFIG_OFS:
            begin
               config_reg <= merge_strb(config_reg, w_data, w_strb);
               cfg_error <= 1'b0;
            end
            GRC_RATE_OFS: rate_reg <= merge_strb(rate_reg, w_data, w_strb);
            GRC_TOTAL_OFS: total_reg <= merge_strb(total_reg, w_data, w_strb);
            default: ;
         endcase
      end
   end

   always_comb
   begin
      rd_data = 32'h00000000;
      rd_resp = GRC_RESP_OKAY;
      unique case (s_axi_araddr)
         GRC_CTRL_OFS: rd_data = ctrl_reg;
         GRC_CONFIG_OFS: rd_data = config_reg;
         GRC_RATE_OFS: rd_data = rate_reg;
         GRC_TOTAL_OFS: rd_data = total_reg;
         GRC_STATUS_OFS:
         begin
            rd_data[GRC_ST_ARMED_BIT] = st == ST_ARMED;
            rd_data[GRC_ST_DELAY_BIT] = st == ST_DELAY;
            rd_data[GRC_ST_RUN_BIT] = st == ST_RUN;
            rd_data[GRC_ST_DONE_BIT] = st == ST_DONE;
            rd_data[GRC_ST_ERR_BIT] = cfg_error;
            rd_data[GRC_ST_GATE_BIT] = gif.level;
         end
         GRC_COUNT_OFS: rd_data = 32'(total_cnt);
         default: rd_resp = GRC_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= GRC_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arready && s_axi_arvalid)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_resp;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Sequencer; a disable write wins over every other transition
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= ST_IDLE;
      else if (ce)
      begin
         if (ctrl_wr && !en_wr)
            st <= ST_IDLE;
         else
         begin
            unique case (st)
               ST_IDLE, ST_DONE:
                  if (arm_req)
                     st <= ST_ARMED;
               ST_ARMED:
                  if (gif.opened)
                     st <= ST_DELAY;
               ST_DELAY:
                  if (sample_tick && delay_cnt == lead_len - 4'h1)
                     st <= ST_RUN;
               ST_RUN:
                  if (sample_tick)
                  begin
                     if (hit_total)
                        st <= ST_DONE;
                     else if (boundary && !gif.level)
                        st <= ST_ARMED;
                  end
            endcase
         end
      end
   end

   // Lead-in burns the samples that the memory refresh costs after gate start
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         delay_cnt <= 4'h0;
      else if (ce)
      begin
         if (st != ST_DELAY)
            delay_cnt <= 4'h0;
         else if (sample_tick)
            delay_cnt <= delay_cnt + 4'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_idx <= '0;
         total_cnt <= '0;
      end
      else if (ce)
      begin
         if (arm_req)
            total_cnt <= '0;
         else if (st == ST_RUN && sample_tick)
            total_cnt <= total_cnt + CNT_W'(1);
         if (st == ST_ARMED && gif.opened)
            run_idx <= '0;
         else if (st == ST_RUN && sample_tick)
            run_idx <= run_idx + CNT_W'(1);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sample_strobe <= 1'b0;
         replay_active <= 1'b0;
         replay_done <= 1'b0;
      end
      else if (ce)
      begin
         sample_strobe <= st == ST_RUN && sample_tick;
         replay_active <= st == ST_DELAY || st == ST_RUN;
         replay_done <= st == ST_DONE;
      end
   end

   sequence s_run_tick;
      ce && st == ST_RUN && sample_tick && !hit_total;
   endsequence

   sequence s_gate_open;
      ce && st == ST_ARMED && gif.opened;
   endsequence

   property p_end_on_boundary;
      @(posedge aclk) disable iff (!aresetn)
      (s_run_tick ##0 (boundary && !gif.level && !ctrl_wr)) |=> st == ST_ARMED;
   endproperty
   a_end_on_boundary: assert property (p_end_on_boundary)
      else $error("gate end at boundary did not pause");

   property p_keep_off_boundary;
      @(posedge aclk) disable iff (!aresetn)
      (s_run_tick ##0 (!boundary && !(ctrl_wr && !en_wr))) |=> st == ST_RUN;
   endproperty
   a_keep_off_boundary: assert property (p_keep_off_boundary)
      else $error("replay paused off an alignment boundary");

   property p_align_table;
      @(posedge aclk) disable iff (!aresetn)
      (chan_cfg == GRC_CH_ONE || (chan_cfg == GRC_CH_TWO_SPLIT && !fifo_mode))
         |-> align_len == 4'h8;
   endproperty
   a_align_table: assert property (p_align_table)
      else $error("alignment wrong for single channel");

   property p_lead_one;
      @(posedge aclk) disable iff (!aresetn)
      (chan_cfg == GRC_CH_ONE && rate_reg < GRC_RATE_5M) |-> lead_len == 4'h7;
   endproperty
   a_lead_one: assert property (p_lead_one)
      else $error("single channel lead-in wrong");

   property p_lead_two;
      @(posedge aclk) disable iff (!aresetn)
      (chan_cfg == GRC_CH_TWO_SAME) |-> lead_len == (rate_reg < GRC_RATE_2M5 ? 4'h3 : 4'h6);
   endproperty
   a_lead_two: assert property (p_lead_two)
      else $error("two channel lead-in wrong");

   property p_lead_four;
      @(posedge aclk) disable iff (!aresetn)
      (chan_cfg == GRC_CH_FOUR && fifo_mode)
         |-> (lead_len == (rate_reg < GRC_RATE_1M25 ? 4'h2 : 4'h3) && align_len == 4'h2);
   endproperty
   a_lead_four: assert property (p_lead_four)
      else $error("four channel FIFO lead-in wrong");

   property p_bad_mode;
      @(posedge aclk) disable iff (!aresetn)
      (ce && ctrl_wr && en_wr && !mode_ok && st == ST_IDLE) |=> (st == ST_IDLE && cfg_error);
   endproperty
   a_bad_mode: assert property (p_bad_mode)
      else $error("invalid gate mode armed the sequencer");

   property p_fixed_delay;
      @(posedge aclk) disable iff (!aresetn)
      (ce && st == ST_DELAY && sample_tick && delay_cnt == lead_len - 4'h1 && !ctrl_wr)
         |=> st == ST_RUN;
   endproperty
   a_fixed_delay: assert property (p_fixed_delay)
      else $error("lead-in did not end on its count");

   property p_resume;
      @(posedge aclk) disable iff (!aresetn)
      (s_gate_open ##0 !ctrl_wr) |=> (st == ST_DELAY && run_idx == '0);
   endproperty
   a_resume: assert property (p_resume)
      else $error("gate open did not restart replay");

   property p_total_stop;
      @(posedge aclk) disable iff (!aresetn)
      (ce && st == ST_RUN && sample_tick && hit_total && !ctrl_wr) |=> st == ST_DONE;
   endproperty
   a_total_stop: assert property (p_total_stop)
      else $error("total count did not stop replay");

   property p_fifo_no_done;
      @(posedge aclk) disable iff (!aresetn)
      (fifo_mode && st != ST_DONE) |=> st != ST_DONE;
   endproperty
   a_fifo_no_done: assert property (p_fifo_no_done)
      else $error("FIFO mode stopped on total count");

   property p_index_step;
      @(posedge aclk) disable iff (!aresetn)
      (ce && st == ST_RUN && sample_tick) |=> run_idx == $past(run_idx) + CNT_W'(1);
   endproperty
   a_index_step: assert property (p_index_step)
      else $error("sample index did not advance");
endmodule : grc_top

// ---- src/grc_pkg.sv ----
// Shared constants of the gated replay controller: register map, fields, mode codes,
// alignment and lead-in tables.
// Assumes a 32-bit AXI4-Lite register bus and a one-cycle sample tick per sample.
package grc_pkg;
   localparam int GRC_ADDR_W = 8;
   localparam logic [7:0] GRC_CTRL_OFS = 8'h00;
   localparam logic [7:0] GRC_CONFIG_OFS = 8'h04;
   localparam logic [7:0] GRC_RATE_OFS = 8'h08;
   localparam logic [7:0] GRC_TOTAL_OFS = 8'h0C;
   localparam logic [7:0] GRC_STATUS_OFS = 8'h10;
   localparam logic [7:0] GRC_COUNT_OFS = 8'h14;
   localparam int GRC_CTRL_EN_BIT = 0;
   localparam int GRC_CTRL_FIFO_BIT = 1;
   localparam int GRC_CFG_MODE_LSB = 0;
   localparam int GRC_CFG_CHAN_LSB = 4;
   localparam int GRC_ST_ARMED_BIT = 0;
   localparam int GRC_ST_DELAY_BIT = 1;
   localparam int GRC_ST_RUN_BIT = 2;
   localparam int GRC_ST_DONE_BIT = 3;
   localparam int GRC_ST_ERR_BIT = 4;
   localparam int GRC_ST_GATE_BIT = 5;
   localparam logic [31:0] GRC_CTRL_RST = 32'h00000000;
   localparam logic [31:0] GRC_CONFIG_RST = 32'h00000000;
   localparam logic [31:0] GRC_RATE_RST = 32'h00000000;
   localparam logic [31:0] GRC_TOTAL_RST = 32'h00000000;
   localparam logic [2:0] GATE_RISING_EDGE_MODE = 3'h0;
   localparam logic [2:0] GATE_FALLING_EDGE_MODE = 3'h1;
   localparam logic [1:0] GRC_CH_ONE = 2'h0;
   localparam logic [1:0] GRC_CH_TWO_SPLIT = 2'h1;
   localparam logic [1:0] GRC_CH_TWO_SAME = 2'h2;
   localparam logic [1:0] GRC_CH_FOUR = 2'h3;
   localparam logic [31:0] GRC_RATE_5M = 32'h004C4B40;
   localparam logic [31:0] GRC_RATE_2M5 = 32'h002625A0;
   localparam logic [31:0] GRC_RATE_1M25 = 32'h001312D0;
   localparam logic [3:0] GRC_ALIGN_8 = 4'h8;
   localparam logic [3:0] GRC_ALIGN_4 = 4'h4;
   localparam logic [3:0] GRC_ALIGN_2 = 4'h2;
   localparam logic [3:0] GRC_LEAD_1CH_LO = 4'h7;
   localparam logic [3:0] GRC_LEAD_1CH_HI = 4'hC;
   localparam logic [3:0] GRC_LEAD_2CH_LO = 4'h3;
   localparam logic [3:0] GRC_LEAD_2CH_HI = 4'h6;
   localparam logic [3:0] GRC_LEAD_4CH_LO = 4'h2;
   localparam logic [3:0] GRC_LEAD_4CH_HI = 4'h3;
   localparam logic [1:0] GRC_RESP_OKAY = 2'h0;
   localparam logic [1:0] GRC_RESP_SLVERR = 2'h2;
endpackage : grc_pkg

// ---- src/grc_gate_if.sv ----
// Link between the replay sequencer and the gate edge detector.
// Sequencer drives the selected gate mode; detector returns gate events.
`timescale 1ns/1ns
interface grc_gate_if;
   logic [2:0] mode;
   logic opened;
   logic level;
   modport det (input mode, output opened, output level);
   modport ctl (output mode, input opened, input level);
endinterface : grc_gate_if

// ---- src/grc_gate_detect.sv ----
// Gate edge detector: turns the trigger input into gate-open pulses and a gate level.
// Trigger input is taken as synchronous to aclk.
`timescale 1ns/1ns
module grc_gate_detect
   import grc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic trig_in,
   grc_gate_if.det gif
);
   logic trig_prev;
   logic rise;
   logic fall;
   logic open_evt;
   logic close_evt;

   assign rise = trig_in && !trig_prev;
   assign fall = !trig_in && trig_prev;
   assign open_evt = (gif.mode == GATE_RISING_EDGE_MODE && rise) ||
                     (gif.mode == GATE_FALLING_EDGE_MODE && fall);
   assign close_evt = (gif.mode == GATE_RISING_EDGE_MODE && fall) ||
                      (gif.mode == GATE_FALLING_EDGE_MODE && rise);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_prev <= 1'b0;
         gif.opened <= 1'b0;
         gif.level <= 1'b0;
      end
      else if (ce)
      begin
         trig_prev <= trig_in;
         gif.opened <= open_evt;
         if (open_evt)
            gif.level <= 1'b1;
         else if (close_evt)
            gif.level <= 1'b0;
      end
   end

   property p_rising_open;
      @(posedge aclk) disable iff (!aresetn)
      (ce && gif.mode == GATE_RISING_EDGE_MODE && trig_in && !trig_prev)
         |=> (gif.opened && gif.level);
   endproperty
   a_rising_open: assert property (p_rising_open)
      else $error("rising edge did not open gate");

   property p_falling_open;
      @(posedge aclk) disable iff (!aresetn)
      (ce && gif.mode == GATE_FALLING_EDGE_MODE && !trig_in && trig_prev)
         |=> (gif.opened && gif.level);
   endproperty
   a_falling_open: assert property (p_falling_open)
      else $error("falling edge did not open gate");

   property p_falling_close;
      @(posedge aclk) disable iff (!aresetn)
      (ce && gif.mode == GATE_FALLING_EDGE_MODE && trig_in && !trig_prev) |=> !gif.level;
   endproperty
   a_falling_close: assert property (p_falling_close)
      else $error("rising edge did not close gate");
endmodule : grc_gate_detect

// ---- tb/grc_gate_src.sv ----
// Gate source model: drives the external trigger line from a gate level and a polarity.
// Assumes the bench changes gate and pol just after a rising edge of aclk.
`timescale 1ns/1ns
module grc_gate_src
(
   input wire logic pol,
   input wire logic gate,
   output logic trig_in
);
   // Falling-edge mode idles high, so an open gate is the low level
   assign trig_in = gate ^ pol;
endmodule : grc_gate_src

// ---- tb/gated_replay_control_tb.sv ----
// Bench for the gated replay controller: AXI4-Lite register access and gated runs.
// Assumes ce held high and a sample tick on every fourth clock.
`timescale 1ns/1ns
module gated_replay_control_tb
   import grc_pkg::*;
;
   localparam logic [1:0] CH [6] = '{GRC_CH_ONE, GRC_CH_TWO_SPLIT, GRC_CH_TWO_SPLIT,
      GRC_CH_TWO_SAME, GRC_CH_FOUR, GRC_CH_FOUR};
   localparam logic [5:0] FI = 6'h24;
   localparam logic [3:0] AL [6] = '{GRC_ALIGN_8, GRC_ALIGN_8, GRC_ALIGN_4, GRC_ALIGN_4,
      GRC_ALIGN_4, GRC_ALIGN_2};
   localparam logic [3:0] LO [6] = '{GRC_LEAD_1CH_LO, GRC_LEAD_1CH_LO, GRC_LEAD_2CH_LO,
      GRC_LEAD_2CH_LO, GRC_LEAD_2CH_LO, GRC_LEAD_4CH_LO};
   localparam logic [3:0] HI [6] = '{GRC_LEAD_1CH_HI, GRC_LEAD_1CH_HI, GRC_LEAD_2CH_HI,
      GRC_LEAD_2CH_HI, GRC_LEAD_2CH_HI, GRC_LEAD_4CH_HI};
   localparam logic [31:0] TH [6] = '{GRC_RATE_5M, GRC_RATE_5M, GRC_RATE_2M5, GRC_RATE_2M5,
      GRC_RATE_2M5, GRC_RATE_1M25};
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, gate = 1'b0, pol = 1'b0, tick = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, trig, strobe, active, done;
   logic [1:0] bresp, rresp, rr, br, tcnt = 2'h0;
   int fails = 0, cmp_count = 0;
   grc_gate_src u_src (.pol(pol), .gate(gate), .trig_in(trig));
   grc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trig_in(trig), .sample_tick(tick), .sample_strobe(strobe),
      .replay_active(active), .replay_done(done));
   initial forever #4 aclk = ~aclk;
   always_ff @(posedge aclk)
   begin
      tcnt <= tcnt + 2'h1;
      tick <= (tcnt == 2'h3);
   end
   task test_done;
      $display("Compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
   endtask : chk
   // A wait that runs out of its bound ends the run as a failure
   task guard(input int i);
      if (i >= 400)
      begin
         fails++;
         test_done;
      end
   endtask : guard
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 400; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            bready <= 1'b0;
            br = bresp;
            break;
         end
      end
      guard(i);
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] e);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 400; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            rd = rdata;
            rr = rresp;
            break;
         end
      end
      guard(i);
      chk(rd, e);
   endtask : rchk
   task wtick;
      int i;
      for (i = 0; i < 400; i++)
      begin
         @(posedge aclk);
         if (tick)
            break;
      end
      guard(i);
   endtask : wtick
   // Opens the gate right on a tick and counts ticks up to the first released sample
   task open_gate(input logic [31:0] e);
      int i;
      int n;
      wtick;
      gate <= 1'b1;
      n = 0;
      for (i = 0; i < 400 && !strobe; i++)
      begin
         @(posedge aclk);
         if (tick)
            n++;
      end
      guard(i);
      chk(n, e);
   endtask : open_gate
   initial
   begin
      int r, k, j, i, e;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(GRC_CTRL_OFS, GRC_CTRL_RST);
      rchk(GRC_CONFIG_OFS, GRC_CONFIG_RST);
      rchk(GRC_RATE_OFS, GRC_RATE_RST);
      rchk(GRC_TOTAL_OFS, GRC_TOTAL_RST);
      rchk(8'h18, 32'h0);
      chk(rr, GRC_RESP_SLVERR);
      wr(8'h1C, 32'h1);
      chk(br, GRC_RESP_SLVERR);
      for (r = 0; r < 6; r++)
         for (k = 0; k < 2; k++)
         begin
            pol <= k[0];
            wr(GRC_CONFIG_OFS, {26'h0, CH[r], 1'b0, 3'(k)});
            wr(GRC_RATE_OFS, TH[r] - 32'h1 + 32'(k));
            // A total of one would end a standard run at once, so FIFO runs prove it is ignored
            wr(GRC_TOTAL_OFS, FI[r] ? 32'h1 : 32'h100);
            // Gate closes after sample 5: the pause lands on the first boundary at or past six samples
            e = ((6 + AL[r] - 1) / AL[r]) * AL[r];
            wr(GRC_CTRL_OFS, {30'h0, FI[r], 1'b1});
            for (j = 1; j < 3; j++)
            begin
               open_gate(32'(k ? HI[r] : LO[r]) + 32'h1);
               repeat (4) wtick;
               gate <= 1'b0;
               for (i = 0; i < 400 && active; i++)
                  @(posedge aclk);
               guard(i);
               rchk(GRC_COUNT_OFS, 32'(j * e));
               chk(rd % 32'(AL[r]), 32'h0);
               chk(32'(rd >= 32'(6 * j) && rd <= 32'(14 * j)), 32'h1);
            end
            rchk(GRC_STATUS_OFS, 32'h1 << GRC_ST_ARMED_BIT);
            chk(32'(rd[GRC_ST_ARMED_BIT]), 32'h1);
            wr(GRC_CTRL_OFS, 32'h0);
         end
      wr(GRC_CONFIG_OFS, 32'h2);
      // Flip the line only once no edge mode is selected, so the gate level stays low
      pol <= 1'b0;
      wr(GRC_CTRL_OFS, 32'h1);
      rchk(GRC_STATUS_OFS, 32'h1 << GRC_ST_ERR_BIT);
      wr(GRC_CTRL_OFS, 32'h0);
      wr(GRC_CONFIG_OFS, 32'h0);
      wr(GRC_RATE_OFS, 32'h3E8);
      wr(GRC_TOTAL_OFS, 32'h5);
      wr(GRC_CTRL_OFS, 32'h1);
      open_gate(32'(GRC_LEAD_1CH_LO) + 32'h1);
      for (i = 0; i < 400 && !done; i++)
         @(posedge aclk);
      guard(i);
      rchk(GRC_COUNT_OFS, 32'h5);
      chk(32'(active), 32'h0);
      test_done;
   end
endmodule : gated_replay_control_tb
